// >>> hw/nvmac_core.sv
// core end: sequences reads and writes and services the interrupt
`timescale 1ns/1ps
module nvmac_core
  import nvmac_pkg::*;
(
  input wire logic CLK_I, // system clock
  input wire logic RST_I, // synchronous reset
  nvmac_if.core BUS, // register port toward the device
  input wire logic REQ_I, // one-cycle operation request
  input wire logic WRITE_I, // 1 write, 0 read
  input wire logic [4:0] ADDR_I, // byte address
  input wire logic [7:0] WDATA_I, // write byte
  input wire logic GIE_I, // global_irq_mask: global interrupt enable
  input wire logic IRQEN_I, // nvm_irq_enable
  input wire logic STACK_FULL_I, // stack full, no vectoring
  input wire logic SLEEP_REQ_I, // request to enter sleep
  output logic BUSY_O, // operation in progress
  output logic DONE_O, // one-cycle completion pulse
  output logic [7:0] RDATA_O, // read byte
  output logic VECTOR_O, // one-cycle vector to handler
  output logic SLEEP_OK_O // sleep may be entered now
);
  `include "nvmac_consts.svh"

  typedef enum {C_IDLE, C_ADDR, C_DATA, C_EN, C_GO, C_POLL, C_POLL2, C_LOAD,
    C_TAKE} nvmac_cst_e;
  nvmac_cst_e st_reg;
  logic wr_reg, gie_mask_reg;
  logic [4:0] a_reg;
  logic [7:0] d_reg;
  logic [1:0] sel;
  logic stb;
  logic [7:0] wd;
  logic [2:0] go_bit;

  // bit index, so it must be wide enough to name the write start bit
  assign go_bit = wr_reg ? 3'(`NVMAC_BIT_WRGO) : 3'(`NVMAC_BIT_RDGO);
  assign BUSY_O = (st_reg != C_IDLE);
  assign SLEEP_OK_O = !BUSY_O && !SLEEP_REQ_I ? 1'b1 : !BUSY_O;
  // vector only when enabled globally, not masked during write start
  assign VECTOR_O = BUS.irq_flag && IRQEN_I && GIE_I && !gie_mask_reg && !STACK_FULL_I;
  assign BUS.irq_ack = VECTOR_O;

  // command encoder for each sequence step
  always_comb begin
    sel = `NVMAC_SEL_CTRL;
    stb = 1'b0;
    wd = 8'h00;
    case (st_reg)
      C_ADDR: begin
        sel = `NVMAC_SEL_ADDR;
        stb = 1'b1;
        wd = {3'h0, a_reg};
      end
      C_DATA: begin
        sel = `NVMAC_SEL_DATA;
        stb = 1'b1;
        wd = d_reg;
      end
      C_EN: begin
        stb = 1'b1;
        wd[wr_reg ? `NVMAC_BIT_WRITE_ENABLE_BIT : `NVMAC_BIT_READ_ENABLE_BIT] = 1'b1;
      end
      C_GO: begin
        stb = 1'b1;
        wd[wr_reg ? `NVMAC_BIT_WRITE_ENABLE_BIT : `NVMAC_BIT_READ_ENABLE_BIT] = 1'b1;
        wd[go_bit] = 1'b1;
      end
      C_LOAD, C_TAKE: begin
        sel = `NVMAC_SEL_DATA;
      end
      default: begin
        sel = `NVMAC_SEL_CTRL;
      end
    endcase
  end
  assign BUS.sel = sel;
  assign BUS.wr_stb = stb;
  assign BUS.wdata = wd;

  // sequencer: read order is enable, address, start; write order address, data, enable, start
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_reg <= C_IDLE;
      wr_reg <= 1'b0;
      a_reg <= 5'h00;
      d_reg <= 8'h00;
      DONE_O <= 1'b0;
      RDATA_O <= 8'h00;
      gie_mask_reg <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      case (st_reg)
        C_IDLE: begin
          if (REQ_I && !SLEEP_REQ_I) begin
            wr_reg <= WRITE_I;
            a_reg <= ADDR_I;
            d_reg <= WDATA_I;
            st_reg <= WRITE_I ? C_ADDR : C_EN;
          end
        end
        C_ADDR: st_reg <= wr_reg ? C_DATA : C_GO;
        C_DATA: st_reg <= C_EN;
        C_EN: begin
          gie_mask_reg <= wr_reg;
          st_reg <= wr_reg ? C_GO : C_ADDR;
        end
        C_GO: st_reg <= C_POLL;
        C_POLL: begin
          gie_mask_reg <= 1'b0;
          st_reg <= C_POLL2;
        end
        C_POLL2: begin
          // rdata holds control as sampled last cycle
          if (!BUS.rdata[go_bit]) begin
            st_reg <= wr_reg ? C_IDLE : C_LOAD;
            DONE_O <= wr_reg;
          end
        end
        // rdata is registered, so the data byte shows one cycle after sel moves
        C_LOAD: st_reg <= C_TAKE;
        C_TAKE: begin
          RDATA_O <= BUS.rdata;
          DONE_O <= 1'b1;
          st_reg <= C_IDLE;
        end
        default: st_reg <= C_IDLE;
      endcase
    end
  end
endmodule

// >>> hw/nvmac_dev.sv
// device end: nonvolatile byte memory with address, data and control registers
//
// How it works
// - write enable clear blocks write starts
// - write start launches write, clears on end
// - write start ignored unless enable preset
// - read enable clear blocks read starts
// - read start launches read, clears on end
// - read start ignored unless enable preset
// - software never sets both starts together
// - read data lands in data register
// - software polls read start before data
// - software loads address, data, then enable, start
// - software masks global interrupts around write start
// - write length set by free-running timer
// - write end always sets interrupt flag
// - flag vectors when enabled, cleared on service
// - reset clears control and data registers
// - control bits seven to four read zero
// - software avoids sleep during cycles
// - thirty-two bytes, five-bit address, reset zero
`timescale 1ns/1ps
`include "nvmac_consts.svh"
module nvmac_dev
  import nvmac_pkg::*;
#(
  parameter int DEPTH = `NVMAC_DEPTH,
  parameter int TIMER_DIV = `NVMAC_TIMER_DIV,
  parameter logic [7:0] WRITE_TICKS = `NVMAC_WRITE_TICKS
) (
  input wire logic CLK_I, // system clock
  input wire logic RST_I, // power-on reset, synchronous
  nvmac_if.dev BUS, // core-side register port
  output logic BUSY_O // high while a read or write cycle runs
);

  logic [7:0] mem [DEPTH];
  logic [`NVMAC_AW-1:0] addr_reg;
  logic [7:0] data_reg;
  logic write_enable_bit_reg, wrgo_reg, read_enable_bit_reg, rdgo_reg;
  logic flag_reg;
  logic [7:0] rdata_reg;
  logic [7:0] wcnt_reg;
  logic [3:0] rcnt_reg;
  nvmac_state_e state_reg;
  logic tick;
  logic ctrl_wr, wr_start, rd_start, wr_done, rd_done;

  //////////////////////////////////////////////////////////////////////////
  nvmac_wtimer #(.DIV(TIMER_DIV)) u_timer (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_o(tick)
  );

  // start qualification uses enable bits as they stood before this write
  assign ctrl_wr = BUS.wr_stb && (BUS.sel == `NVMAC_SEL_CTRL);
  assign wr_start = ctrl_wr && BUS.wdata[`NVMAC_BIT_WRGO] && write_enable_bit_reg
    && (state_reg == NVMAC_IDLE);
  assign rd_start = ctrl_wr && BUS.wdata[`NVMAC_BIT_RDGO] && read_enable_bit_reg
    && !BUS.wdata[`NVMAC_BIT_WRGO] && (state_reg == NVMAC_IDLE);
  assign wr_done = (state_reg == NVMAC_WRITE) && tick && (wcnt_reg == 8'h01);
  assign rd_done = (state_reg == NVMAC_READ) && (rcnt_reg == 4'h1);
  assign BUSY_O = (state_reg != NVMAC_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg <= NVMAC_IDLE;
      wcnt_reg <= 8'h00;
      rcnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        NVMAC_IDLE: begin
          if (wr_start) begin
            state_reg <= NVMAC_WRITE;
            wcnt_reg <= WRITE_TICKS;
          end else if (rd_start) begin
            state_reg <= NVMAC_READ;
            rcnt_reg <= `NVMAC_READ_CYC;
          end
        end
        NVMAC_WRITE: begin
          if (tick) begin
            wcnt_reg <= wcnt_reg - 8'h01;
          end
          if (wr_done) begin
            state_reg <= NVMAC_IDLE;
          end
        end
        NVMAC_READ: begin
          rcnt_reg <= rcnt_reg - 4'h1;
          if (rd_done) begin
            state_reg <= NVMAC_IDLE;
          end
        end
        default: begin
          state_reg <= NVMAC_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register; hardware clears start bits at cycle end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      {write_enable_bit_reg, wrgo_reg, read_enable_bit_reg, rdgo_reg} <= `NVMAC_RST_CTRL;
    end else begin
      if (ctrl_wr) begin
        write_enable_bit_reg <= BUS.wdata[`NVMAC_BIT_WRITE_ENABLE_BIT];
        read_enable_bit_reg <= BUS.wdata[`NVMAC_BIT_READ_ENABLE_BIT];
      end
      // a start bit only sticks when the cycle really launched
      if (wr_start) begin
        wrgo_reg <= 1'b1;
      end else if (wr_done) begin
        wrgo_reg <= 1'b0;
      end
      if (rd_start) begin
        rdgo_reg <= 1'b1;
      end else if (rd_done) begin
        rdgo_reg <= 1'b0;
      end
    end
  end

  // address register, upper bits not implemented
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      addr_reg <= `NVMAC_RST_ADDR;
    end else if (BUS.wr_stb && BUS.sel == `NVMAC_SEL_ADDR && !BUSY_O) begin
      addr_reg <= BUS.wdata[`NVMAC_AW-1:0];
    end
  end

  // data register; read result overwrites it when the read ends
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      data_reg <= `NVMAC_RST_DATA;
    end else if (rd_done) begin
      data_reg <= mem[addr_reg];
    end else if (BUS.wr_stb && BUS.sel == `NVMAC_SEL_DATA && !BUSY_O) begin
      data_reg <= BUS.wdata;
    end
  end

  // array; contents survive reset as nonvolatile storage would
  always_ff @(posedge CLK_I) begin
    if (wr_done) begin
      mem[addr_reg] <= data_reg;
    end
  end

  // interrupt request flag; set wins over service clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flag_reg <= 1'b0;
    end else if (wr_done) begin
      flag_reg <= 1'b1;
    end else if (BUS.irq_ack) begin
      flag_reg <= 1'b0;
    end
  end
  assign BUS.irq_flag = flag_reg;

  // registered read mux
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_reg <= 8'h00;
    end else begin
      case (BUS.sel)
        `NVMAC_SEL_ADDR: rdata_reg <= {3'h0, addr_reg};
        `NVMAC_SEL_DATA: rdata_reg <= data_reg;
        `NVMAC_SEL_CTRL: rdata_reg <= {4'h0, write_enable_bit_reg, wrgo_reg, read_enable_bit_reg, rdgo_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign BUS.rdata = rdata_reg;
endmodule

// >>> hw/nvmac_wtimer.sv
// free-running write timer: ticks on its own slow cadence, not tied to writes
`timescale 1ns/1ps
`include "nvmac_consts.svh"
module nvmac_wtimer #(
  parameter int DIV = `NVMAC_TIMER_DIV
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  output logic tick_o // one-cycle tick
);
  logic [7:0] cnt_reg;

  // divider phase is independent of when a write starts, so length varies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_reg == 8'(DIV - 1));
      cnt_reg <= (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule

// >>> pkg/nvmac_consts.svh
// constants for the byte-wide nonvolatile memory access block
`ifndef NVMAC_CONSTS_SVH
`define NVMAC_CONSTS_SVH
`define NVMAC_DEPTH 32
`define NVMAC_AW 5
`define NVMAC_DW 8
// register selectors on the core-side special register port
`define NVMAC_SEL_ADDR 2'h0
`define NVMAC_SEL_DATA 2'h1
`define NVMAC_SEL_CTRL 2'h2
// control register bit positions
`define NVMAC_BIT_RDGO 0
`define NVMAC_BIT_READ_ENABLE_BIT 1
`define NVMAC_BIT_WRGO 2
`define NVMAC_BIT_WRITE_ENABLE_BIT 3
// reset values
`define NVMAC_RST_ADDR 5'h00
`define NVMAC_RST_DATA 8'h00
`define NVMAC_RST_CTRL 4'h0
// cycles a read takes inside the array
`define NVMAC_READ_CYC 4'h2
// default length of a timed write, in ticks of the write timer
`define NVMAC_WRITE_TICKS 8'h10
// default divider of the free-running write timer, in system clocks
`define NVMAC_TIMER_DIV 7
`endif

// >>> pkg/nvmac_if.sv
// special register port between processor core and nonvolatile memory block
`timescale 1ns/1ps
interface nvmac_if;
  logic [1:0] sel;
  logic wr_stb;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq_flag;
  logic irq_ack;
  modport dev (input sel, input wr_stb, input wdata, output rdata,
    output irq_flag, input irq_ack);
  modport core (output sel, output wr_stb, output wdata, input rdata,
    input irq_flag, output irq_ack);
endinterface

// >>> pkg/nvmac_pkg.sv
// types shared by both ends of the nonvolatile memory access block
package nvmac_pkg;
  typedef enum {NVMAC_IDLE, NVMAC_READ, NVMAC_WRITE} nvmac_state_e;
  typedef logic [1:0] nvmac_sel_t;
endpackage

// >>> verif/nvmac_chk.sv
// assertions on the register port between core end and device end
`timescale 1ns/1ps
`include "nvmac_consts.svh"
module nvmac_chk (
  input wire logic CLK_I, // system clock
  input wire logic RST_I, // sync reset
  input wire logic [1:0] sel, // register select
  input wire logic wr_stb, // write strobe
  input wire logic [7:0] wdata, // write data
  input wire logic [7:0] rdata, // read data
  input wire logic irq_flag, // request flag
  input wire logic irq_ack // service pulse
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////////
  // control register write seen on the port
  wire ctl_wr = wr_stb && sel == `NVMAC_SEL_CTRL;
  ////////////////////////////////////////////////////////////////////////////////
  // readback masking of unimplemented bits
  a_ctrl_hi_zero: assert property (sel == `NVMAC_SEL_CTRL |=> rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_addr_hi_zero: assert property (sel == `NVMAC_SEL_ADDR |=> rdata[7:5] == 3'h0)
    else $error("address upper bits not zero");
  // flag only drops through a service pulse
  a_flag_fall_ack: assert property ($fell(irq_flag) |-> $past(irq_ack))
    else $error("flag dropped without service");
  a_ack_clears: assert property (irq_flag && irq_ack |=> !irq_flag)
    else $error("service left flag set");
  a_ack_pending: assert property (irq_ack |-> irq_flag)
    else $error("service without pending flag");
  // core sequencing of start bits
  a_no_dual_go: assert property (ctl_wr
    |-> !(wdata[`NVMAC_BIT_RDGO] && wdata[`NVMAC_BIT_WRGO]))
    else $error("both start bits written");
  a_wr_after_en: assert property (ctl_wr && wdata[`NVMAC_BIT_WRGO]
    |-> $past(ctl_wr) && $past(wdata[`NVMAC_BIT_WRITE_ENABLE_BIT]))
    else $error("write start not right after enable");
  a_rd_keeps_en: assert property (ctl_wr && wdata[`NVMAC_BIT_RDGO]
    |-> wdata[`NVMAC_BIT_READ_ENABLE_BIT])
    else $error("read start without read enable");
endmodule

// >>> verif/tb_eeprom_byte_access_control.sv
// self-checking bench: core and device joined, plus a device driven directly
`timescale 1ns/1ps
`include "nvmac_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_eeprom_byte_access_control;
  localparam logic [1:0] sa = `NVMAC_SEL_ADDR;
  localparam logic [1:0] sd = `NVMAC_SEL_DATA;
  localparam logic [1:0] sc = `NVMAC_SEL_CTRL;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic req = 1'b0, wr = 1'b0, gie = 1'b1, irqen = 1'b0, sfull = 1'b0, sleep = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  logic busy, done, vec, sleep_ok, busy2;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  nvmac_if bus ();
  nvmac_if bus2 ();
  ////////////////////////////////////////////////////////////////////////////////
  // short write timer keeps each write a handful of cycles
  nvmac_dev #(.TIMER_DIV(2), .WRITE_TICKS(8'h02)) i_nvmac_dev (.CLK_I(CLK_I), .RST_I(RST_I),
    .BUS(bus), .BUSY_O());
  nvmac_core i_nvmac_core (.CLK_I(CLK_I), .RST_I(RST_I), .BUS(bus), .REQ_I(req), .WRITE_I(wr),
    .ADDR_I(addr), .WDATA_I(wd), .GIE_I(gie), .IRQEN_I(irqen), .STACK_FULL_I(sfull),
    .SLEEP_REQ_I(sleep), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rd), .VECTOR_O(vec),
    .SLEEP_OK_O(sleep_ok));
  // second device, driven by the bench to try what the core never does
  nvmac_dev #(.TIMER_DIV(2), .WRITE_TICKS(8'h02)) i_nvmac_dev_2 (.CLK_I(CLK_I), .RST_I(RST_I),
    .BUS(bus2), .BUSY_O(busy2));
  nvmac_chk i_nvmac_chk (.CLK_I(CLK_I), .RST_I(RST_I), .sel(bus.sel), .wr_stb(bus.wr_stb),
    .wdata(bus.wdata), .rdata(bus.rdata), .irq_flag(bus.irq_flag), .irq_ack(bus.irq_ack));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #4 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // register port tasks; a gap cycle between writes avoids re-raising the strobe
  task automatic reg_wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge CLK_I);
    bus2.sel = s;
    bus2.wdata = d;
    bus2.wr_stb = 1'b1;
    @(negedge CLK_I);
    bus2.wr_stb = 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] s, output logic [7:0] v);
    @(negedge CLK_I);
    bus2.sel = s;
    @(negedge CLK_I);
    v = bus2.rdata;
  endtask
  // wait for hardware to drop a start bit, bounded
  task automatic poll(input int b);
    logic [7:0] v = 8'hFF;
    for (int k = 0; k < 50 && v[b] !== 1'b0; k++) reg_rd(sc, v);
    `CHK(v[b], 1'b0)
  endtask
  // one user request through the core end
  task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge CLK_I);
    req = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge CLK_I);
    req = 1'b0;
    `CHK(sleep_ok, 1'b0)
    for (int k = 0; k < 200 && done !== 1'b1; k++) @(negedge CLK_I);
    `CHK(done, 1'b1)
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] v;
    bus2.sel = sa;
    bus2.wr_stb = 1'b0;
    bus2.wdata = 8'h00;
    bus2.irq_ack = 1'b0;
    repeat (2) @(negedge CLK_I);
    RST_I = 1'b0;
    reg_rd(sc, v);
    `CHK(v, 8'h00)
    reg_rd(sd, v);
    `CHK(v, 8'h00)
    reg_rd(sa, v);
    `CHK(v, 8'h00)
    // starts written together with their enables, or after the enables are cleared, are ignored
    reg_wr(sc, 8'hFF);
    reg_rd(sc, v);
    `CHK(v, 8'h0A)
    reg_wr(sc, 8'h08);
    reg_wr(sc, 8'h09);
    reg_rd(sc, v);
    `CHK(v, 8'h08)
    reg_wr(sc, 8'h02);
    reg_wr(sc, 8'h06);
    reg_rd(sc, v);
    `CHK(v, 8'h02)
    // write at the top address, address change during it is ignored
    reg_wr(sa, 8'hFF);
    reg_wr(sd, 8'h3C);
    reg_wr(sc, 8'h08);
    reg_wr(sc, 8'h0C);
    `CHK(busy2, 1'b1)
    reg_wr(sa, 8'h00);
    poll(`NVMAC_BIT_WRGO);
    `CHK(bus2.irq_flag, 1'b1)
    reg_rd(sa, v);
    `CHK(v, 8'h1F)
    bus2.irq_ack = 1'b1;
    @(negedge CLK_I);
    bus2.irq_ack = 1'b0;
    `CHK(bus2.irq_flag, 1'b0)
    reg_wr(sd, 8'h00);
    reg_wr(sc, 8'h02);
    reg_wr(sc, 8'h03);
    poll(`NVMAC_BIT_RDGO);
    reg_rd(sd, v);
    `CHK(v, 8'h3C)
    // requests are refused while sleep is asked for
    sleep = 1'b1;
    req = 1'b1;
    @(negedge CLK_I);
    req = 1'b0;
    @(negedge CLK_I);
    `CHK(busy, 1'b0)
    sleep = 1'b0;
    // core writes and reads back, flag set with its source disabled
    op(1'b1, 5'h1F, 8'hA5);
    `CHK(bus.irq_flag, 1'b1)
    op(1'b1, 5'h00, 8'h5A);
    op(1'b0, 5'h1F, 8'h00);
    `CHK(rd, 8'hA5)
    op(1'b0, 5'h00, 8'h00);
    `CHK(rd, 8'h5A)
    // full stack holds off vectoring, then service clears the flag
    sfull = 1'b1;
    irqen = 1'b1;
    repeat (3) @(negedge CLK_I);
    `CHK(vec, 1'b0)
    // global enable off still holds it back
    gie = 1'b0;
    sfull = 1'b0;
    @(negedge CLK_I);
    `CHK(vec, 1'b0)
    gie = 1'b1;
    // vector is combinational; let it settle before looking
    #1;
    `CHK(vec, 1'b1)
    @(negedge CLK_I);
    `CHK(bus.irq_flag, 1'b0)
    tally_and_finish();
  end
endmodule
